// ===== rtl/bcs_charge_seq.sv
// Charge sequencer top: command register and charging state machine
`timescale 1ns/1ps
`include "bcs_params.svh"

// Functional notes
// - Stable charger input starts a charge cycle in pre-charge.
// - Pre-charge until battery passes full-rate threshold, then full-rate.
// - Full-rate until termination voltage, then hold constant voltage.
// - End-of-charge may end a cycle only from constant-voltage state.
// - Auto start/stop bit 1 selects automatic end-of-charge, else manual.
// - Auto mode ends cycle when current falls below selected level.
// - The 0.1C level equals ten percent of full-rate current.
// - Current must stay below level for the programmed delay before ending.
// - Halt bit at 0x39 stops charging; resume bit restarts it.
// - Halt and resume are write-only; at most one set per write.
// - End-of-charge control bits reset to 00, disabling detection.
// - Top current bits 11 disable limit, overvoltage, thermal regulation.
// - In automatic mode, charging restarts when battery is more than restart offset below termination.
module bcs_charge_seq #(
    parameter int ADC_W   = 12,
    parameter int ICHG_W  = 6,
    parameter int DLY_W   = 24,
    parameter int STAB_W  = 16,
    parameter int STABLE_CYC = `BCS_STABLE_CYC
) (
    // Clock, reset, enable
    input  wire logic              i_clk_sys,
    input  wire logic              i_arst_n,
    input  wire logic              i_ce,
    // Register write port
    input  wire logic              i_reg_wr,
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [7:0]        i_reg_wdata,
    // Configuration from the register file
    input  wire logic              i_auto_start_stop,
    input  wire logic [1:0]        i_eoc_ctrl,
    input  wire logic [ICHG_W-1:0] i_charge_current_setting,
    input  wire logic [6:0]        i_eoc_pct,
    input  wire logic [DLY_W-1:0]  i_eoc_delay_cyc,
    // Thresholds in measurement units
    input  wire logic [ADC_W-1:0]  i_full_rate_thr,
    input  wire logic [ADC_W-1:0]  i_term_thr,
    input  wire logic [ADC_W-1:0]  i_restart_ofs,
    input  wire logic [ADC_W-1:0]  i_full_current,
    // Analog comparator and measurement inputs (asynchronous)
    input  wire logic              i_charger_supply_input,
    input  wire logic [ADC_W-1:0]  i_battery_voltage,
    input  wire logic [ADC_W-1:0]  i_charge_current,
    // Charger controls
    output logic                   o_precharge_current,
    output logic                   o_full_rate_en,
    output logic                   o_const_v_en,
    output logic                   o_current_limit_en,
    output logic                   o_batt_ovp_en,
    output logic                   o_thermal_reg_en,
    output logic                   o_eoc_done,
    output logic [2:0]             o_state
);
    // ================================================================
    // Input synchronisation
    logic               supply_ok;
    logic [2*ADC_W-1:0] meas_sync;
    logic [2*ADC_W-1:0] meas_prev_reg;
    logic [2*ADC_W-1:0] meas_reg;
    logic               meas_steady;
    logic [ADC_W-1:0]   vbat_s;
    logic [ADC_W-1:0]   ichg_s;

    bcs_sync #(.W(1)) u_sync_in (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_async   (i_charger_supply_input),
        .o_sync    (supply_ok)
    );
    bcs_sync #(.W(2*ADC_W)) u_sync_meas (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_async   ({i_battery_voltage, i_charge_current}),
        .o_sync    (meas_sync)
    );

    // ================================================================
    // Measurement capture
    // Bits of a word may cross in different cycles; a word is taken
    // only when two samples in a row agree, so no torn value reaches
    // the comparators. Cost: two more cycles of latency, and a value
    // that changes on every cycle is never taken.
    assign meas_steady = (meas_sync == meas_prev_reg);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meas_prev_reg <= '0;
            meas_reg      <= '0;
        end else if (i_ce) begin
            meas_prev_reg <= meas_sync;
            if (meas_steady) begin
                meas_reg <= meas_sync;
            end
        end
    end

    assign {vbat_s, ichg_s} = meas_reg;

    // ================================================================
    // Input qualification: supply must be present for a stable span
    logic [STAB_W-1:0] stab_span;
    logic              supply_stable;
    logic              stable_dly_reg;
    logic              stable_rise;

    assign stab_span = STAB_W'(STABLE_CYC);

    // A supply glitch restarts qualification from zero
    bcs_timer #(.W(STAB_W)) u_stab (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_cond    (supply_ok),
        .i_span    (stab_span),
        .o_done    (supply_stable)
    );

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stable_dly_reg <= 1'b0;
        end else if (i_ce) begin
            stable_dly_reg <= supply_stable;
        end
    end
    assign stable_rise = supply_stable && !stable_dly_reg;

    // ================================================================
    // Command decode of the write-only halt/resume bits
    logic cmd_hit;
    logic halt_cmd;
    logic resume_cmd;

    assign cmd_hit    = i_reg_wr && (i_reg_addr == `BCS_CMD_OFS);
    // Commands act only in the cycle of the write and leave no state,
    // so a later strobe cannot replay an old command
    // Both bits in one write is illegal; it is ignored as a whole
    assign halt_cmd   = cmd_hit && i_reg_wdata[`BCS_CMD_HALT_BIT]
                        && !i_reg_wdata[`BCS_CMD_RESUME_BIT];
    assign resume_cmd = cmd_hit && i_reg_wdata[`BCS_CMD_RESUME_BIT]
                        && !i_reg_wdata[`BCS_CMD_HALT_BIT];

    // ================================================================
    // End-of-charge threshold: percentage of full-rate current
    // Rounds down, so the level never sits above the exact fraction
    function automatic logic [ADC_W-1:0] pct_of(
        input logic [ADC_W-1:0] full,
        input logic [6:0]       pct
    );
        logic [ADC_W+6:0] prod;
        prod   = full * pct;
        pct_of = ADC_W'(prod / `BCS_PCT_FULL);
    endfunction

    logic [ADC_W-1:0] eoc_thr;
    logic             eoc_enabled;
    logic             auto_mode;
    logic             below_eoc;
    logic             eoc_hit;
    logic             in_cv;

    assign eoc_thr     = pct_of(i_full_current, i_eoc_pct);
    // Detection stays masked while the control bits are at reset 00
    assign eoc_enabled = (i_eoc_ctrl != `BCS_EOC_CTRL_RST);
    assign auto_mode   = (i_auto_start_stop == `BCS_AUTO_ON);
    assign below_eoc   = (ichg_s < eoc_thr);

    // Any condition dropping out restarts the delay count
    bcs_timer #(.W(DLY_W)) u_eoc_dly (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_cond    (in_cv && auto_mode && eoc_enabled && below_eoc),
        .i_span    (i_eoc_delay_cyc),
        .o_done    (eoc_hit)
    );

    // ================================================================
    // Voltage comparisons
    logic             above_full_rate;
    logic             at_term;
    logic [ADC_W-1:0] restart_lvl;
    logic             below_restart;

    assign above_full_rate = (vbat_s > i_full_rate_thr);
    assign at_term         = (vbat_s >= i_term_thr);
    // An offset at or above termination gives zero, which never restarts
    assign restart_lvl     = (i_term_thr > i_restart_ofs) ?
                             ADC_W'(i_term_thr - i_restart_ofs) : '0;
    assign below_restart   = (vbat_s < restart_lvl);

    // ================================================================
    // Charge state machine
    bcs_pkg::bcs_state_t state_reg;
    bcs_pkg::bcs_state_t state_next;
    logic                charging;

    assign in_cv    = (state_reg == bcs_pkg::BCS_CONST_V);
    assign charging = (state_reg == bcs_pkg::BCS_PRECHARGE)
                      || (state_reg == bcs_pkg::BCS_FULLRATE) || in_cv;

    always_comb begin
        state_next = state_reg;
        // Supply loss outranks a halt, and a halt outranks any phase change
        if (!supply_stable) begin
            // Input loss aborts whatever is running
            state_next = bcs_pkg::BCS_IDLE;
        end else if (halt_cmd) begin
            state_next = bcs_pkg::BCS_HALTED;
        end else begin
            unique case (state_reg)
                bcs_pkg::BCS_IDLE: begin
                    // A fresh qualification starts a cycle, not a held supply
                    if (stable_rise) begin
                        state_next = bcs_pkg::BCS_PRECHARGE;
                    end
                end
                bcs_pkg::BCS_PRECHARGE: begin
                    if (above_full_rate) begin
                        state_next = bcs_pkg::BCS_FULLRATE;
                    end
                end
                bcs_pkg::BCS_FULLRATE: begin
                    if (at_term) begin
                        state_next = bcs_pkg::BCS_CONST_V;
                    end
                end
                bcs_pkg::BCS_CONST_V: begin
                    // Only the CV phase may terminate the cycle
                    if (eoc_hit) begin
                        state_next = bcs_pkg::BCS_DONE;
                    end
                end
                bcs_pkg::BCS_DONE: begin
                    // Voltage restart only in automatic mode
                    if (resume_cmd || (auto_mode && below_restart)) begin
                        state_next = bcs_pkg::BCS_PRECHARGE;
                    end
                end
                bcs_pkg::BCS_HALTED: begin
                    // Restart thresholds are ignored until resumed
                    if (resume_cmd) begin
                        state_next = bcs_pkg::BCS_PRECHARGE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= bcs_pkg::BCS_IDLE;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // ================================================================
    // Registered charger controls
    logic hicur_mode;
    // Only the two top bits pick the mode; the rest still sets current
    assign hicur_mode = (i_charge_current_setting[ICHG_W-1 -: 2]
                         == `BCS_HICUR_CODE);

    // Controls follow the next state, so they switch on the same edge
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_precharge_current <= 1'b0;
            o_full_rate_en      <= 1'b0;
            o_const_v_en        <= 1'b0;
            o_eoc_done          <= 1'b0;
        end else if (i_ce) begin
            o_precharge_current <= (state_next == bcs_pkg::BCS_PRECHARGE);
            o_full_rate_en      <= (state_next == bcs_pkg::BCS_FULLRATE);
            o_const_v_en        <= (state_next == bcs_pkg::BCS_CONST_V);
            o_eoc_done          <= (state_next == bcs_pkg::BCS_DONE);
        end
    end

    // Protections come out of reset on, so the charger is never left
    // unguarded; only the high-current setting (top current bits 11) turns them off
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_current_limit_en  <= 1'b1;
            o_batt_ovp_en       <= 1'b1;
            o_thermal_reg_en    <= 1'b1;
        end else if (i_ce) begin
            o_current_limit_en  <= !hicur_mode;
            o_batt_ovp_en       <= !hicur_mode;
            o_thermal_reg_en    <= !hicur_mode;
        end
    end

    assign o_state = state_reg;

    logic unused_charging;
    assign unused_charging = charging;
endmodule // bcs_charge_seq

// ===== rtl/bcs_params.svh
// Constants for the battery charge sequencer
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH
// ================================================================
// Register offsets
`define BCS_CMD_OFS          8'h39
// ================================================================
// Command register field positions (write-only bits)
`define BCS_CMD_HALT_BIT     0
`define BCS_CMD_RESUME_BIT   1
// ================================================================
// Configuration encodings and reset values
`define BCS_EOC_CTRL_RST     2'h0
`define BCS_HICUR_CODE       2'h3
`define BCS_AUTO_ON          1'h1
// End-of-charge level: percent of full-rate current (0.1C is 10 %)
`define BCS_EOC_PCT_01C      7'h0a
`define BCS_PCT_FULL         7'h64
// ================================================================
// Timing: input stability and delay tick
`define BCS_STABLE_US        10
`define BCS_CLK_MHZ          50
`define BCS_STABLE_CYC       (`BCS_STABLE_US * `BCS_CLK_MHZ)
`define BCS_TICK_MS          1
`define BCS_TICK_CYC         (`BCS_TICK_MS * 1000 * `BCS_CLK_MHZ)
`endif

// ===== rtl/bcs_pkg.sv
// Types of the battery charge sequencer
package bcs_pkg;
    typedef enum logic [2:0] {
        BCS_IDLE,
        BCS_PRECHARGE,
        BCS_FULLRATE,
        BCS_CONST_V,
        BCS_DONE,
        BCS_HALTED
    } bcs_state_t;
endpackage

// ===== rtl/bcs_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module bcs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_arst_n,
    input  wire logic         i_ce,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // bcs_sync

// ===== rtl/bcs_timer.sv
// Cycle counter that reports when a condition held for a full span
`timescale 1ns/1ps
module bcs_timer #(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_arst_n,
    input  wire logic         i_ce,
    // Condition and span
    input  wire logic         i_cond,
    input  wire logic [W-1:0] i_span,
    output logic              o_done
);
    logic [W-1:0] cnt_reg;

    // Any break in the condition restarts the count from zero
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_reg <= '0;
        end else if (i_ce) begin
            if (!i_cond) begin
                cnt_reg <= '0;
            end else if (cnt_reg < i_span) begin
                cnt_reg <= cnt_reg + W'(1);
            end
        end
    end

    assign o_done = i_cond && (cnt_reg >= i_span);
endmodule // bcs_timer

// ===== dv/bcs_charge_seq_assertions.sv
// Port-level checks for the charge sequencer
`timescale 1ns/1ps
`include "bcs_params.svh"
module bcs_charge_seq_assertions #(
    parameter int ICHG_W = 6
) (
    // Clock and reset
    input wire logic              i_clk_sys,
    input wire logic              i_arst_n,
    input wire logic              i_ce,
    // Register writes and setting
    input wire logic              i_reg_wr,
    input wire logic [7:0]        i_reg_addr,
    input wire logic [7:0]        i_reg_wdata,
    input wire logic [ICHG_W-1:0] i_charge_current_setting,
    // Charger controls
    input wire logic              o_precharge_current,
    input wire logic              o_full_rate_en,
    input wire logic              o_const_v_en,
    input wire logic              o_current_limit_en,
    input wire logic              o_batt_ovp_en,
    input wire logic              o_thermal_reg_en,
    input wire logic              o_eoc_done,
    input wire logic [2:0]        o_state
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // ============================================================
    // Decoded command writes
    wire cmd_wr = i_reg_wr && i_ce && (i_reg_addr == `BCS_CMD_OFS);
    wire wr_halt = cmd_wr && (i_reg_wdata[1:0] == 2'h1);
    wire wr_resume = cmd_wr && (i_reg_wdata[1:0] == 2'h2);
    wire hicur = i_charge_current_setting[ICHG_W-1 -: 2] == `BCS_HICUR_CODE;
    wire prot = o_current_limit_en && o_batt_ovp_en && o_thermal_reg_en;
    // ============================================================
    // Assertions
    state_range_a: assert property (o_state <= 3'h5)
        else $error("state code out of range");
    out_onehot_a: assert property (
        o_precharge_current == (o_state == 3'h1) &&
        o_full_rate_en == (o_state == 3'h2) &&
        o_const_v_en == (o_state == 3'h3) && o_eoc_done == (o_state == 3'h4))
        else $error("controls disagree with state");
    idle_exit_a: assert property (
        o_state == 3'h0 && !wr_halt |=> o_state inside {3'h0, 3'h1})
        else $error("idle left for a state other than pre-charge");
    pre_exit_a: assert property (
        o_state == 3'h1 |=> o_state inside {3'h0, 3'h1, 3'h2, 3'h5})
        else $error("pre-charge left for an illegal state");
    full_exit_a: assert property (
        o_state == 3'h2 |=> o_state inside {3'h0, 3'h2, 3'h3, 3'h5})
        else $error("full-rate left for an illegal state");
    eoc_from_cv_a: assert property (
        $rose(o_eoc_done) |-> $past(o_state) == 3'h3)
        else $error("end of charge not reached from constant voltage");
    halt_cmd_a: assert property (
        wr_halt && o_state inside {3'h1, 3'h2, 3'h3} |=>
        o_state inside {3'h0, 3'h5})
        else $error("halt write did not stop charging");
    halt_hold_a: assert property (
        o_state == 3'h5 && !wr_resume |=> o_state inside {3'h0, 3'h5})
        else $error("halted state left without resume");
    resume_cmd_a: assert property (
        o_state == 3'h5 && wr_resume |=> o_state inside {3'h0, 3'h1})
        else $error("resume did not restart in pre-charge");
    hicur_prot_a: assert property (i_ce && hicur |=>
        !o_current_limit_en && !o_batt_ovp_en && !o_thermal_reg_en)
        else $error("protections on in high-current mode");
    prot_on_a: assert property (i_ce && !hicur |=> prot)
        else $error("protections off in normal mode");
    cover property (o_state == 3'h4);
    cover property (o_state == 3'h5 && wr_resume);
    cover property (hicur && !prot);
endmodule // bcs_charge_seq_assertions

bind bcs_charge_seq bcs_charge_seq_assertions #(.ICHG_W(ICHG_W)) u_chk (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .i_charge_current_setting(i_charge_current_setting),
    .o_precharge_current(o_precharge_current),
    .o_full_rate_en(o_full_rate_en), .o_const_v_en(o_const_v_en),
    .o_current_limit_en(o_current_limit_en),
    .o_batt_ovp_en(o_batt_ovp_en), .o_thermal_reg_en(o_thermal_reg_en),
    .o_eoc_done(o_eoc_done), .o_state(o_state));

// ===== dv/bcs_host_model.sv
// Host model: command register writes and charger configuration
`timescale 1ns/1ps
`include "bcs_params.svh"
module bcs_host_model (
    // Clock
    input  wire logic  i_clk_sys,
    // Register writes
    output logic       o_reg_wr,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    // Configuration
    output logic       o_auto_start_stop,
    output logic [1:0] o_eoc_ctrl,
    output logic [5:0] o_charge_current_setting
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_auto_start_stop = `BCS_AUTO_ON;
        o_eoc_ctrl = `BCS_EOC_CTRL_RST;
        o_charge_current_setting = 6'h0a;
    end
    // Callers keep halt and resume apart unless a refusal is wanted
    task automatic cmd_write(input logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_wr = 1'b1;
        o_reg_addr = `BCS_CMD_OFS;
        o_reg_wdata = d;
        @(negedge i_clk_sys);
        o_reg_wr = 1'b0;
        // Released bus shows no stale value
        o_reg_addr = ~o_reg_addr;
        o_reg_wdata = ~d;
    endtask
    task automatic configure(input logic a, input logic [1:0] e,
                             input logic [5:0] s);
        @(negedge i_clk_sys);
        o_auto_start_stop = a;
        o_eoc_ctrl = e;
        o_charge_current_setting = s;
    endtask
endmodule // bcs_host_model

// ===== dv/tb.sv
// Self-checking bench for the charge sequencer
`timescale 1ns/1ps
`include "bcs_params.svh"
module tb;
    // ============================================================
    // Stimulus and observation
    localparam logic [11:0] FULL_THR = 12'h2c0;
    localparam logic [11:0] TERM_THR = 12'h420;
    localparam logic [11:0] RST_OFS  = 12'h020;
    localparam logic [11:0] FULL_CUR = 12'h3e8;
    localparam int EOC_I = int'(FULL_CUR) * int'(`BCS_EOC_PCT_01C) / 100;
    localparam logic [11:0] EOC_THR  = 12'(EOC_I);
    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    logic        supply  = 1'b0;
    logic [11:0] vbat    = 12'h100;
    logic [11:0] icur    = 12'h3e8;
    logic [6:0]  pct     = `BCS_EOC_PCT_01C;
    logic [23:0] dly     = 24'h000014;
    logic        ce      = 1'b1;
    logic        precur, eoc_done;
    logic        wr, auto_ss, lim_en, ovp_en, thr_en;
    logic [7:0]  addr, wdata;
    logic [1:0]  eoc_ctrl;
    logic [5:0]  ichg;
    logic [2:0]  state;
    int          miscompares = 0;
    int          samples_checked = 0;
    always #10 clk_sys = ~clk_sys;
    bcs_charge_seq #(.STABLE_CYC(4)) DUT (
        .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_ce(ce),
        .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_auto_start_stop(auto_ss), .i_eoc_ctrl(eoc_ctrl),
        .i_charge_current_setting(ichg), .i_eoc_pct(pct),
        .i_eoc_delay_cyc(dly), .i_full_rate_thr(FULL_THR),
        .i_term_thr(TERM_THR), .i_restart_ofs(RST_OFS),
        .i_full_current(FULL_CUR), .i_charger_supply_input(supply),
        .i_battery_voltage(vbat), .i_charge_current(icur),
        .o_precharge_current(precur), .o_full_rate_en(), .o_const_v_en(),
        .o_current_limit_en(lim_en), .o_batt_ovp_en(ovp_en),
        .o_thermal_reg_en(thr_en), .o_eoc_done(eoc_done), .o_state(state));
    bcs_host_model host (
        .i_clk_sys(clk_sys), .o_reg_wr(wr), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .o_auto_start_stop(auto_ss),
        .o_eoc_ctrl(eoc_ctrl), .o_charge_current_setting(ichg));
    // ============================================================
    // Shared tasks
    task automatic finish_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [11:0] exp,
                         input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
            miscompares++;
        end
    endtask
    task automatic chk_st(input logic [2:0] s);
        check("state", {9'h000, s}, {9'h000, state});
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Bounded wait until the state equals s (eq) or leaves it (!eq)
    task automatic wait_state(input logic [2:0] s, input bit eq);
        int n;
        n = 0;
        while (((state === s) != eq) && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 3000) begin
            $display("CHECK FAILED state wait expected %0h seen %0h",
                     s, state);
            miscompares++;
            finish_test();
        end
    endtask
    // ============================================================
    // Scenarios
    task automatic t_charge();
        supply = 1'b1;
        wait_state(3'h1, 1'b1);
        check("pre current", 12'h001, {11'h000, precur});
        vbat = FULL_THR;
        cycles(20);
        chk_st(3'h1);
        vbat = FULL_THR + 12'h001;
        wait_state(3'h2, 1'b1);
        vbat = TERM_THR;
        wait_state(3'h3, 1'b1);
        icur = EOC_THR - 12'h001;
        cycles(60);
        chk_st(3'h3);
        host.configure(1'b0, 2'h1, 6'h0a);
        cycles(60);
        chk_st(3'h3);
        icur = EOC_THR;
        host.configure(1'b1, 2'h1, 6'h0a);
        cycles(60);
        chk_st(3'h3);
        icur = EOC_THR - 12'h001;
        cycles(20);
        chk_st(3'h3);
        wait_state(3'h4, 1'b1);
        check("eoc done", 12'h001, {11'h000, eoc_done});
    endtask
    task automatic t_restart();
        vbat = TERM_THR - RST_OFS + 12'h001;
        cycles(40);
        chk_st(3'h4);
        vbat = TERM_THR - RST_OFS - 12'h001;
        icur = FULL_CUR;
        wait_state(3'h2, 1'b1);
    endtask
    task automatic t_halt();
        host.cmd_write(8'h01);
        chk_st(3'h5);
        host.cmd_write(8'h03);
        vbat = 12'h100;
        cycles(20);
        chk_st(3'h5);
        host.cmd_write(8'h02);
        wait_state(3'h1, 1'b1);
    endtask
    task automatic t_supply();
        supply = 1'b0;
        wait_state(3'h0, 1'b1);
    endtask
    task automatic t_hicur();
        host.configure(1'b1, 2'h1, {`BCS_HICUR_CODE, 4'h0});
        cycles(3);
        check("prot off", 12'h000, {9'h000, lim_en, ovp_en, thr_en});
        host.configure(1'b1, 2'h1, 6'h2f);
        cycles(3);
        check("prot on", 12'h007, {9'h000, lim_en, ovp_en, thr_en});
    endtask
    // Clock enable low freezes qualification; release lets it finish
    task automatic t_freeze();
        ce = 1'b0;
        supply = 1'b1;
        cycles(20);
        chk_st(3'h0);
        ce = 1'b1;
        wait_state(3'h1, 1'b1);
    endtask
    initial begin
        cycles(16);
        arst_n = 1'b1;
        cycles(2);
        chk_st(3'h0);
        t_charge();
        t_restart();
        t_halt();
        t_supply();
        t_hicur();
        t_freeze();
        finish_test();
    end
endmodule // tb
